//--- pkg/vdg_pkg.sv
`default_nettype none
package vdg_pkg;

	// ************************************************************
	// widths and field sizes
	// ************************************************************
	localparam int VDG_CODE_W = 8;
	localparam int VDG_STRAP_W = 8;
	localparam int VDG_REF_W = 14;

	// ************************************************************
	// code tables, reference in quarter-millivolt units
	// ************************************************************
	localparam logic [VDG_CODE_W-1:0] VDG_CODE_FIRST_ON = 8'h02;
	localparam logic [VDG_REF_W-1:0] VDG_REF_TOP_Q = 14'h1900;
	localparam logic [VDG_REF_W-1:0] VDG_REF_STEP_Q = 14'h0019;
	localparam logic [VDG_REF_W-1:0] VDG_TBL5_BASE_Q = 14'h1838;
	localparam logic [VDG_REF_W-1:0] VDG_TBL5_STEP_Q = 14'h0064;
	localparam logic [VDG_REF_W-1:0] VDG_TBL6_BASE_Q = 14'h1838;
	localparam logic [VDG_REF_W-1:0] VDG_TBL6_STEP_Q = 14'h0032;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int VDG_CLOCK_HZ = 50000000;
	localparam int VDG_INTERVAL_MIN = 2;
	localparam logic [VDG_STRAP_W-1:0] VDG_INTERVAL_RESET = 8'h00;

	typedef enum logic [1:0]
	{
		VDG_TBL_8BIT = 2'b00,
		VDG_TBL_5BIT = 2'b01,
		VDG_TBL_6BIT = 2'b10
	} vdg_table_t;

	// pin bundle, all asynchronous to clock
	typedef struct packed
	{
		logic enable;
		logic soft_start_strap;
		logic error_above_ramp;
		logic phase_align_trip;
		logic [VDG_CODE_W-1:0] code;
		logic [VDG_CODE_W-1:0] code_driven;
		logic [VDG_STRAP_W-1:0] frequency_set_strap;
	} vdg_pins_t;

	function automatic logic [VDG_REF_W-1:0] vdg_ref_calc(
		input logic [VDG_REF_W-1:0] base,
		input logic [VDG_REF_W-1:0] step,
		input logic [VDG_CODE_W-1:0] index
	);
		logic [2*VDG_REF_W-1:0] prod;
		prod = step * {{(VDG_REF_W-VDG_CODE_W){1'b0}}, index};
		return base - prod[VDG_REF_W-1:0];
	endfunction : vdg_ref_calc

endpackage : vdg_pkg
`default_nettype wire

//--- design/vdg_code_decode.sv
`default_nettype none
module vdg_code_decode
	import vdg_pkg::*;
(
	input wire logic soft_start_strap, // high: strap tied to supply
	input wire logic [VDG_CODE_W-1:0] code_raw, // pin levels
	input wire logic [VDG_CODE_W-1:0] code_driven, // pin actually driven
	output vdg_table_t table_mode, // selected table
	output logic [VDG_CODE_W-1:0] code_resolved, // after weak pulls
	output logic [VDG_REF_W-1:0] reference_setting, // quarter mV
	output logic output_off // code means output off
);

	// ************************************************************
	// table select and weak pulls
	// ************************************************************
	logic pull_level;
	logic top_bit;

	always_comb
	begin
		// pulls follow the strap, not the decoded table, so no loop
		pull_level = ~soft_start_strap;
		for (int i = 0; i < VDG_CODE_W; i++)
		begin
			code_resolved[i] = code_driven[i] ? code_raw[i] : pull_level;
		end
		top_bit = code_resolved[VDG_CODE_W-1];
		if (!soft_start_strap)
			table_mode = VDG_TBL_8BIT;
		else if (top_bit)
			table_mode = VDG_TBL_5BIT;
		else
			table_mode = VDG_TBL_6BIT;
	end

	// ************************************************************
	// reference lookup
	// ************************************************************
	always_comb
	begin
		output_off = 1'b0;
		case (table_mode)
			VDG_TBL_8BIT:
			begin
				output_off = code_resolved < VDG_CODE_FIRST_ON;
				reference_setting = output_off ? '0 :
					vdg_ref_calc(VDG_REF_TOP_Q, VDG_REF_STEP_Q,
					code_resolved - VDG_CODE_FIRST_ON);
			end
			VDG_TBL_5BIT:
				reference_setting = vdg_ref_calc(VDG_TBL5_BASE_Q,
					VDG_TBL5_STEP_Q, {3'h0, code_resolved[4:0]});
			VDG_TBL_6BIT:
				reference_setting = vdg_ref_calc(VDG_TBL6_BASE_Q,
					VDG_TBL6_STEP_Q, {2'h0, code_resolved[5:0]});
			default:
				reference_setting = '0;
		endcase
	end

endmodule : vdg_code_decode
`default_nettype wire

//--- design/vdg_pwm_top.sv
// Contract
// - interval length in clock cycles set by the frequency strap
// - pulse stays low while error level is below the ramp and the trip is low
// - pulse rises on crossing, stays high until crossing back
// - at most one rising edge of the pulse per switching interval
// - low pulse: upper off, lower on; high pulse: reverse
// - trip above filtered error flags transient and forces pulse on, within the one-rise limit
// - strap and top code bit select 8-bit, 5-bit or 6-bit table
// - 8-bit table: codes 0,1 off, code 2 is 1.6 V, 6.25 mV steps
// - undriven code pins read high in 8-bit mode, low otherwise
// - enable low disables all controller operation except table_mode, which still follows the strap and code pins
`default_nettype none
module vdg_pwm_top
	import vdg_pkg::*;
#(
	parameter int STRAP_W = VDG_STRAP_W
)
(
	input wire logic clock, // 50 MHz system clock
	input wire logic nrst, // asynchronous reset, active low
	input wire logic enable, // enable pin
	input wire logic soft_start_strap, // high: strap tied to supply
	input wire logic error_above_ramp, // error level above ramp
	input wire logic phase_align_trip, // trip above filtered error
	input wire logic [VDG_CODE_W-1:0] voltage_code_inputs, // code pins
	input wire logic [VDG_CODE_W-1:0] voltage_code_driven, // pin driven
	input wire logic [STRAP_W-1:0] frequency_set_strap, // interval cycles
	output logic pulse_out, // channel pulse to gate driver
	output logic upper_gate_on, // upper transistor command
	output logic lower_gate_on, // lower synchronous transistor command
	output logic transient_flag, // trip event active
	output logic interval_start, // first cycle of an interval
	output logic output_off, // decoded code means off, or enable low
	output logic [1:0] table_mode, // selected table
	output logic [VDG_REF_W-1:0] reference_setting // quarter mV
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (STRAP_W != VDG_STRAP_W)
	begin : g_bad_width
		$error("frequency strap width must match the pin bundle");
	end

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	vdg_pins_t pins_meta_reg;
	vdg_pins_t pins_reg;
	vdg_pins_t pins_now;

	always_comb
	begin
		pins_now.enable = enable;
		pins_now.soft_start_strap = soft_start_strap;
		pins_now.error_above_ramp = error_above_ramp;
		pins_now.phase_align_trip = phase_align_trip;
		pins_now.code = voltage_code_inputs;
		pins_now.code_driven = voltage_code_driven;
		pins_now.frequency_set_strap = frequency_set_strap;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pins_meta_reg <= '0;
			pins_reg <= '0;
		end
		else
		begin
			pins_meta_reg <= pins_now;
			pins_reg <= pins_meta_reg;
		end
	end

	// ************************************************************
	// code decode
	// ************************************************************
	vdg_table_t mode_next;
	logic [VDG_CODE_W-1:0] code_next;
	logic [VDG_REF_W-1:0] ref_next;
	logic off_next;

	vdg_code_decode u_decode (
		.soft_start_strap(pins_reg.soft_start_strap),
		.code_raw(pins_reg.code),
		.code_driven(pins_reg.code_driven),
		.table_mode(mode_next),
		.code_resolved(code_next),
		.reference_setting(ref_next),
		.output_off(off_next)
	);

	logic en;

	assign en = pins_reg.enable;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			table_mode <= VDG_TBL_8BIT;
			reference_setting <= '0;
			output_off <= 1'b1;
		end
		else
		begin
			table_mode <= mode_next;
			reference_setting <= en ? ref_next : '0;
			output_off <= off_next | ~en;
		end
	end

	// ************************************************************
	// switching interval clock
	// ************************************************************
	// strap is read each reload, so a new value takes effect at the
	// next interval; values below the minimum are clamped
	logic [STRAP_W-1:0] interval_count_reg;
	logic [STRAP_W-1:0] period_m1;
	logic start_next;

	always_comb
	begin
		period_m1 = pins_reg.frequency_set_strap - STRAP_W'(1);
		if (pins_reg.frequency_set_strap < STRAP_W'(VDG_INTERVAL_MIN))
			period_m1 = STRAP_W'(VDG_INTERVAL_MIN - 1);
		start_next = en && interval_count_reg == '0;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			interval_count_reg <= VDG_INTERVAL_RESET;
		else if (!en)
			interval_count_reg <= VDG_INTERVAL_RESET;
		else if (interval_count_reg == '0)
			interval_count_reg <= period_m1;
		else
			interval_count_reg <= interval_count_reg - STRAP_W'(1);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			interval_start <= 1'b0;
		else
			interval_start <= start_next;
	end

	// ************************************************************
	// pulse modulator
	// ************************************************************
	// the trip forces the pulse but still honours the one-rise limit,
	// trading a little transient speed for no double pulses
	logic rose_reg;
	logic want_high;
	logic may_rise;
	logic pulse_next;
	logic kill;

	always_comb
	begin
		kill = ~en | off_next;
		want_high = pins_reg.error_above_ramp |
			pins_reg.phase_align_trip;
		may_rise = start_next | ~rose_reg;
		if (kill)
			pulse_next = 1'b0;
		else if (pulse_out)
			pulse_next = want_high;
		else
			pulse_next = want_high & may_rise;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			rose_reg <= 1'b0;
		else if (!en)
			rose_reg <= 1'b0;
		else if (pulse_next && !pulse_out)
			rose_reg <= 1'b1;
		else if (start_next)
			rose_reg <= 1'b0;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pulse_out <= 1'b0;
			upper_gate_on <= 1'b0;
			lower_gate_on <= 1'b0;
			transient_flag <= 1'b0;
		end
		else
		begin
			pulse_out <= pulse_next;
			upper_gate_on <= pulse_next;
			lower_gate_on <= en & ~pulse_next;
			transient_flag <= ~kill & pins_reg.phase_align_trip;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	one_rise_a: assert property (
		@(posedge clock) disable iff (!nrst)
		$rose(pulse_out) |-> $past(start_next) || !$past(rose_reg))
		else $error("second rising edge inside one interval");

	disable_low_a: assert property (
		@(posedge clock) disable iff (!nrst)
		!en |=> !pulse_out && !upper_gate_on && !lower_gate_on)
		else $error("gates active while disabled");

	off_low_a: assert property (
		@(posedge clock) disable iff (!nrst)
		off_next |=> !pulse_out && !transient_flag)
		else $error("pulse high while code means off");

	gate_pair_a: assert property (
		@(posedge clock) disable iff (!nrst)
		en |=> (upper_gate_on == pulse_out) &&
			(lower_gate_on == !pulse_out))
		else $error("gate commands disagree with pulse");

	hold_low_a: assert property (
		@(posedge clock) disable iff (!nrst)
		!pins_reg.error_above_ramp && !pins_reg.phase_align_trip
		|=> !pulse_out)
		else $error("pulse high with error below ramp");

	cross_rise_a: assert property (
		@(posedge clock) disable iff (!nrst)
		en && !off_next && pins_reg.error_above_ramp && start_next
		|=> pulse_out)
		else $error("pulse missed crossing at interval start");

	trip_force_a: assert property (
		@(posedge clock) disable iff (!nrst)
		en && !off_next && pins_reg.phase_align_trip && may_rise
		|=> transient_flag && pulse_out)
		else $error("trip did not force pulse on");

	interval_len_a: assert property (
		@(posedge clock) disable iff (!nrst)
		start_next && en && pins_reg.frequency_set_strap == 8'h04
		&& $stable(pins_reg.frequency_set_strap) ##1
		en [*4] |=> interval_start)
		else $error("interval length differs from strap");

	top_code_a: assert property (
		@(posedge clock) disable iff (!nrst)
		en && mode_next == VDG_TBL_8BIT && code_next == 8'h02
		|=> reference_setting == VDG_REF_TOP_Q && !output_off)
		else $error("code two does not give top reference");

	table_sel_a: assert property (
		@(posedge clock) disable iff (!nrst)
		pins_reg.soft_start_strap && !pins_reg.code_driven[7]
		|=> table_mode == VDG_TBL_6BIT)
		else $error("undriven top bit not read low in supply mode");

endmodule : vdg_pwm_top
`default_nettype wire

//--- tb/vdg_cpu_model.sv
`default_nettype none
module vdg_cpu_model
	import vdg_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic [VDG_CODE_W-1:0] req_code, // code the processor sends
	input wire logic [VDG_CODE_W-1:0] req_drive, // 1 = pin driven
	output logic [VDG_CODE_W-1:0] code_pins, // pin levels
	output logic [VDG_CODE_W-1:0] code_driven // drive flags
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [VDG_CODE_W-1:0] junk_reg = 8'hA5;

	// released pins wander each cycle so a design reading them is caught
	always @(posedge clock)
		junk_reg <= ~junk_reg;
	assign code_pins = (req_code & req_drive) | (junk_reg & ~req_drive);
	assign code_driven = req_drive;
endmodule : vdg_cpu_model
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
module tb
	import vdg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'h0;
	logic nrst = 1'h0;
	logic en_r = 1'h0, ss_r = 1'h0, err_r = 1'h0, trip_r = 1'h0;
	logic [VDG_CODE_W-1:0] code_r = 8'h02, drv_r = 8'hFF, pins, pins_drv;
	logic [VDG_STRAP_W-1:0] per_r = 8'h08;
	logic pulse_out, upper_gate_on, lower_gate_on, transient_flag;
	logic interval_start, output_off, last_pulse = 1'h0;
	logic [1:0] table_mode;
	logic [VDG_REF_W-1:0] reference_setting;
	int num_errors = 0, checks_done = 0, rises = 0;

	always #10 clock = ~clock;

	vdg_cpu_model u_cpu (.clock(clock), .req_code(code_r), .req_drive(drv_r),
		.code_pins(pins), .code_driven(pins_drv));

	vdg_pwm_top u_dut (.clock(clock), .nrst(nrst), .enable(en_r),
		.soft_start_strap(ss_r), .error_above_ramp(err_r),
		.phase_align_trip(trip_r), .voltage_code_inputs(pins),
		.voltage_code_driven(pins_drv), .frequency_set_strap(per_r),
		.pulse_out(pulse_out), .upper_gate_on(upper_gate_on),
		.lower_gate_on(lower_gate_on), .transient_flag(transient_flag),
		.interval_start(interval_start), .output_off(output_off),
		.table_mode(table_mode), .reference_setting(reference_setting));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic drive(input logic en, ss, err, trip,
		input logic [7:0] code, drv, per);
		@(posedge clock);
		en_r <= en;
		ss_r <= ss;
		err_r <= err;
		trip_r <= trip;
		code_r <= code;
		drv_r <= drv;
		per_r <= per;
	endtask : drive

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask : settle

	// bounded wait on the pulse or on the interval marker
	task automatic wait_hi(input bit want_pulse);
		for (int i = 0; i < 60; i++)
		begin
			@(negedge clock);
			if ((want_pulse ? pulse_out : interval_start) === 1'h1)
				return;
		end
		chk(1'h0, 1'h1);
	endtask : wait_hi

	task automatic dec(input logic ss, input logic [7:0] code, drv,
		input logic [1:0] mode, input logic [13:0] ref_q);
		drive(1'h1, ss, 1'h0, 1'h0, code, drv, 8'h08);
		settle(5);
		chk(table_mode, mode);
		chk(reference_setting, ref_q);
		chk(output_off, ref_q == 14'h0000);
	endtask : dec

	task automatic meas_period(input logic [7:0] per);
		int n;
		drive(1'h1, 1'h0, 1'h0, 1'h0, 8'h02, 8'hFF, per);
		settle(5);
		wait_hi(0);
		wait_hi(0);
		n = 0;
		do
		begin
			@(negedge clock);
			n++;
		end
		while (interval_start !== 1'h1 && n < 60);
		chk(n, per);
	endtask : meas_period

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_pwm;
		drive(1'h1, 1'h0, 1'h1, 1'h0, 8'h02, 8'hFF, 8'h14);
		wait_hi(1);
		chk(upper_gate_on, 1'h1);
		chk(lower_gate_on, 1'h0);
		settle(25);
		chk(pulse_out, 1'h1);
		drive(1'h1, 1'h0, 1'h0, 1'h0, 8'h02, 8'hFF, 8'h14);
		settle(4);
		chk(pulse_out, 1'h0);
		chk(lower_gate_on, 1'h1);
		// a pulse held high over an interval edge has not risen in the
		// new interval, so the refused rise is tried in a fresh one
		wait_hi(0);
		drive(1'h1, 1'h0, 1'h1, 1'h0, 8'h02, 8'hFF, 8'h14);
		settle(4);
		chk(pulse_out, 1'h1);
		drive(1'h1, 1'h0, 1'h0, 1'h0, 8'h02, 8'hFF, 8'h14);
		settle(4);
		chk(pulse_out, 1'h0);
		drive(1'h1, 1'h0, 1'h1, 1'h0, 8'h02, 8'hFF, 8'h14);
		settle(4);
		chk(pulse_out, 1'h0);
		wait_hi(1);
		chk(interval_start, 1'h1);
		drive(1'h1, 1'h0, 1'h0, 1'h0, 8'h02, 8'hFF, 8'h14);
		settle(4);
		wait_hi(0);
		chk(pulse_out, 1'h0);
	endtask : t_pwm

	task automatic t_trip;
		wait_hi(0);
		drive(1'h1, 1'h0, 1'h0, 1'h1, 8'h02, 8'hFF, 8'h14);
		settle(4);
		chk(transient_flag, 1'h1);
		chk(pulse_out, 1'h1);
		drive(1'h1, 1'h0, 1'h0, 1'h0, 8'h02, 8'hFF, 8'h14);
	endtask : t_trip

	task automatic t_off;
		int n;
		drive(1'h1, 1'h0, 1'h1, 1'h1, 8'h01, 8'hFF, 8'h08);
		settle(5);
		n = 0;
		repeat (20)
		begin
			@(negedge clock);
			if (pulse_out !== 1'h0)
				n++;
		end
		chk(n, 0);
		chk(output_off, 1'h1);
		drive(1'h0, 1'h0, 1'h1, 1'h1, 8'h02, 8'hFF, 8'h08);
		settle(5);
		chk({pulse_out, upper_gate_on, lower_gate_on}, 3'h0);
		chk({transient_flag, output_off}, 2'h1);
		chk(reference_setting, 14'h0000);
	endtask : t_off

	// a pulse may rise only once between two interval markers
	always @(negedge clock)
	begin
		if (interval_start === 1'h1)
			rises = 0;
		if (pulse_out === 1'h1 && last_pulse !== 1'h1)
			rises++;
		if (rises > 1)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, rises, 1);
		end
		last_pulse = pulse_out;
	end

	initial
	begin
		#100000;
		num_errors++;
		$display("watchdog expired at %0t", $time);
		final_report();
	end

	initial
	begin
		settle(5);
		chk({output_off, table_mode, pulse_out}, 4'h8);
		@(posedge clock);
		nrst <= 1'h1;
		dec(1'h0, 8'h00, 8'hFF, 2'h0, 14'h0000);
		dec(1'h0, 8'h01, 8'hFF, 2'h0, 14'h0000);
		dec(1'h0, 8'h02, 8'hFF, 2'h0, 14'h1900);
		dec(1'h0, 8'h03, 8'hFF, 2'h0, 14'h18E7);
		dec(1'h0, 8'h82, 8'hFF, 2'h0, 14'h0C80);
		dec(1'h1, 8'h81, 8'hFF, 2'h1, 14'h17D4);
		dec(1'h1, 8'h05, 8'hFF, 2'h2, 14'h173E);
		dec(1'h0, 8'h00, 8'h00, 2'h0, 14'h004B);
		dec(1'h0, 8'h00, 8'hFC, 2'h0, 14'h18E7);
		dec(1'h1, 8'hFF, 8'h00, 2'h2, 14'h1838);
		meas_period(8'h08);
		meas_period(8'h05);
		meas_period(8'h04);
		t_pwm();
		t_trip();
		t_off();
		final_report();
	end
endmodule : tb
`default_nettype wire
